// file: common/nil_map.svh
/*
  Constants of the identification loader and infrared strap block.
  Assumes inclusion by the package and the design file by bare name.
*/
`ifndef NIL_MAP_SVH
`define NIL_MAP_SVH
`define NIL_CLK_DIV 256
`define NIL_HALF_DIV 128
`define NIL_WORDS 8
`define NIL_WORD_BITS 16
`define NIL_READ_OP 3'h6
`define NIL_ADDR_BITS 6
`define NIL_IR_BIT 6
`define NIL_CHANNELS 8
`define NIL_SENSE_CYCLES 4
`define NIL_CMD_LAST 8
`define NIL_DATA_START 10
`define NIL_LAST_BIT 25
`endif

// file: common/nil_pkg.sv
/*
  Types of the identification loader block.
  Assumes the constants header sits alongside.
*/
`include "nil_map.svh"
package nil_pkg;
  typedef enum logic [2:0] {
    NIL_SENSE = 3'h0,
    NIL_SEL = 3'h1,
    NIL_SHIFT = 3'h2,
    NIL_GAP = 3'h3,
    NIL_DONE = 3'h4
  } nil_state_t;
  // Bit-bang control written by software.
  typedef struct packed {
    logic manual;
    logic clock;
    logic select;
    logic writeData;
  } nil_bitbang_t;
  // Identification words loaded from memory.
  typedef struct packed {
    logic [15:0] vendorId;
    logic [15:0] subVendorId;
  } nil_ident_t;
endpackage

// file: hdl/nil_loader.sv
/*
  Loads eight words from the serial memory after reset, offers manual
  bit-bang access, and samples the infrared strap.
  Assumes a 40 MHz clock and a pulled-up chip select line at power-up.
*/
`timescale 1ns/1ps
`include "nil_map.svh"
module nil_loader #(
  parameter logic [15:0] DEFAULT_VENDOR = 16'h0001, // Arbitrary value.
  parameter logic [15:0] DEFAULT_SUBVENDOR = 16'h0002 // Arbitrary value.
) (
  input wire logic clk, // 40 MHz clock.
  input wire logic reset_n, // Async hardware reset, low.
  input wire logic softReset, // One-cycle soft reset pulse.
  input wire nil_pkg::nil_bitbang_t bitbang, // Bit-bang control.
  input wire logic infraredStrap, // Infrared enable strap pin.
  input wire logic nvmReadLine, // Serial data from memory.
  input wire logic nvmSelectIn, // Chip select pin level.
  output logic nvmSerialClock, // Serial clock to memory.
  output logic nvmChipSelect, // Chip select to memory.
  output logic nvmSelectOe, // Chip select output enable.
  output logic nvmWriteLine, // Serial data to memory.
  output logic nvmReadBit, // Read line for software.
  output nil_pkg::nil_ident_t ident, // Loaded identification.
  output logic [127:0] loadedWords, // All eight words.
  output logic loadDone, // Automatic load finished.
  output logic nvmPresent, // Memory sensed.
  output logic [7:0] irModeBits // Modem control bit 6 per channel.
);
  import nil_pkg::*;

  typedef struct packed {
    logic [1:0] strapSync;
    logic [1:0] readSync;
    logic [1:0] selSync;
    nil_state_t state;
    logic [7:0] div;
    logic [5:0] bitCnt;
    logic [2:0] wordCnt;
    logic [15:0] shift;
    logic [127:0] words;
    logic sclk;
    logic cs;
    logic csOe;
    logic wr;
    logic rdBit;
    nil_ident_t id;
    logic done;
    logic present;
    logic [7:0] ir;
  } nil_regs_t;

  nil_regs_t st_reg, st_next;
  logic rstLocal_n;
  logic [1:0] rstPipe;
  logic restart;
  logic tick;
  logic [8:0] cmdWord;

  // Reset release through two flip-flops.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'h1};
    end
  end
  assign rstLocal_n = rstPipe[1];

  // Start bit, read opcode and word address.
  assign cmdWord = {`NIL_READ_OP, 3'h0, st_reg.wordCnt};
  assign restart = softReset;
  assign tick = st_reg.div == 8'(`NIL_HALF_DIV - 1);

  // Next-state logic for the whole block.
  always_comb begin
    st_next = st_reg;
    st_next.strapSync = {st_reg.strapSync[0], infraredStrap};
    st_next.readSync = {st_reg.readSync[0], nvmReadLine};
    st_next.selSync = {st_reg.selSync[0], nvmSelectIn};
    st_next.rdBit = st_reg.readSync[1];
    st_next.div = tick ? 8'h0 : st_reg.div + 8'h1;
    if (restart) begin
      st_next.state = NIL_SENSE;
      st_next.bitCnt = 6'h0;
      st_next.done = 1'h0;
      st_next.csOe = 1'h0;
      st_next.sclk = 1'h0;
      st_next.cs = 1'h0; // A cut frame is ended at once.
      st_next.wr = 1'h0;
    end else begin
      case (st_reg.state)
        NIL_SENSE: begin
          st_next.csOe = 1'h0;
          st_next.ir = {`NIL_CHANNELS{st_reg.strapSync[1]}};
          if (st_reg.bitCnt == 6'(`NIL_SENSE_CYCLES)) begin
            st_next.present = st_reg.selSync[1];
            st_next.bitCnt = 6'h0;
            st_next.wordCnt = 3'h0;
            st_next.id = '{DEFAULT_VENDOR, DEFAULT_SUBVENDOR};
            st_next.state = st_reg.selSync[1] ? NIL_SEL : NIL_DONE;
          end else begin
            st_next.bitCnt = st_reg.bitCnt + 6'h1;
          end
        end
        NIL_SEL: begin
          st_next.csOe = 1'h1;
          st_next.cs = 1'h1;
          st_next.wr = cmdWord[8];
          if (tick) begin
            st_next.state = NIL_SHIFT;
          end
        end
        NIL_SHIFT: begin
          if (tick) begin
            st_next.sclk = !st_reg.sclk;
            if (st_reg.sclk) begin
              // Falling edge: present next command bit.
              st_next.bitCnt = st_reg.bitCnt + 6'h1;
              if (st_reg.bitCnt < 6'(`NIL_CMD_LAST)) begin
                st_next.wr = cmdWord[4'(7) - st_reg.bitCnt[3:0]];
              end else begin
                st_next.wr = 1'h0;
              end
              if (st_reg.bitCnt == 6'(`NIL_LAST_BIT)) begin
                st_next.state = NIL_GAP;
                st_next.cs = 1'h0;
              end
            end else if (st_reg.bitCnt >= 6'(`NIL_DATA_START)) begin
              // Rising edge: capture data bit after dummy zero.
              st_next.shift = {st_reg.shift[14:0], st_reg.readSync[1]};
            end
          end
        end
        NIL_GAP: begin
          if (tick) begin
            st_next.words[st_reg.wordCnt * 16 +: 16] = st_reg.shift;
            if (st_reg.wordCnt == 3'h0) st_next.id.vendorId = st_reg.shift;
            if (st_reg.wordCnt == 3'h1) st_next.id.subVendorId = st_reg.shift;
            st_next.bitCnt = 6'h0;
            st_next.wordCnt = st_reg.wordCnt + 3'h1;
            st_next.state = (st_reg.wordCnt == 3'(`NIL_WORDS - 1)) ?
                            NIL_DONE : NIL_SEL;
          end
        end
        NIL_DONE: begin
          st_next.done = 1'h1;
          st_next.csOe = 1'h1;
          st_next.sclk = bitbang.manual & bitbang.clock;
          st_next.cs = bitbang.manual & bitbang.select;
          st_next.wr = bitbang.manual & bitbang.writeData;
        end
        default: st_next.state = NIL_SENSE;
      endcase
    end
  end

  // State register with constant reset values.
  always_ff @(posedge clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign nvmSerialClock = st_reg.sclk;
  assign nvmChipSelect = st_reg.cs;
  assign nvmSelectOe = st_reg.csOe;
  assign nvmWriteLine = st_reg.wr;
  assign nvmReadBit = st_reg.rdBit;
  assign ident = st_reg.id;
  assign loadedWords = st_reg.words;
  assign loadDone = st_reg.done;
  assign nvmPresent = st_reg.present;
  assign irModeBits = st_reg.ir;

  // Serial clock toggles only on divider ticks while loading.
  sclk_rate_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_SHIFT && $changed(nvmSerialClock) |->
    $past(tick)) else $error("serial clock changed off tick");

  // Without memory the built-in identification stays in place.
  no_mem_skip_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_SENSE && st_next.state == NIL_DONE |=>
    ident == {DEFAULT_VENDOR, DEFAULT_SUBVENDOR})
    else $error("defaults lost without memory");
  // The strap level reaches every channel while sensing.
  strap_copy_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_SENSE && !restart |=>
    irModeBits == {8{$past(st_reg.strapSync[1])}})
    else $error("strap not copied");
  // The synchronised read line is offered to software.
  read_bit_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    nvmReadBit == $past(st_reg.readSync[1]))
    else $error("read line not shown");

  // Manual access follows the software bits one cycle later.
  manual_clk_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_DONE && !restart |=>
    nvmSerialClock == $past(bitbang.manual & bitbang.clock))
    else $error("manual clock wrong");
  // Chip select follows its software bit.
  manual_cs_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_DONE && !restart |=>
    nvmChipSelect == $past(bitbang.manual & bitbang.select))
    else $error("manual select wrong");
  // The write line follows its software bit.
  manual_wr_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_DONE && !restart |=>
    nvmWriteLine == $past(bitbang.manual & bitbang.writeData))
    else $error("manual write wrong");

  // A sensed memory is recorded as present.
  sense_present_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_SENSE && st_next.state == NIL_SEL |=>
    nvmPresent) else $error("presence not latched");
  // A soft reset starts the whole sequence again.
  soft_restart_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    restart |=> st_reg.state == NIL_SENSE && !loadDone)
    else $error("soft reset ignored");
  // A soft reset ends any frame that was under way.
  soft_cut_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    restart |=> !nvmChipSelect && !nvmWriteLine && !nvmSerialClock)
    else $error("frame not cut by soft reset");

  // The select pin is released while it is being sensed.
  oe_sense_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_SENSE |-> !nvmSelectOe)
    else $error("select driven while sensing");
  // Presence only changes during sensing.
  present_hold_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state != NIL_SENSE && !restart |=> $stable(nvmPresent))
    else $error("presence changed late");
  // The strap copy only changes during sensing.
  strap_hold_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state != NIL_SENSE && !restart |=> $stable(irModeBits))
    else $error("strap copy changed late");
  // All channels share one infrared setting.
  ir_all_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    irModeBits == 8'h00 || irModeBits == 8'hff)
    else $error("channels disagree on infrared");

  // The divider wraps after its tick.
  div_wrap_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    tick |=> st_reg.div == 8'h0)
    else $error("divider did not wrap");
  // The serial clock rests low while a frame is being opened.
  sclk_idle_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_SEL |-> !nvmSerialClock)
    else $error("serial clock high at frame start");
  // Each frame opens with select and the start bit high.
  sel_start_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_SEL && tick && !restart |=>
    nvmChipSelect && nvmWriteLine)
    else $error("frame start wrong");
  // The write line is low once the command has been sent.
  write_cmd_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_SHIFT && st_reg.bitCnt > 6'h8 |-> !nvmWriteLine)
    else $error("write line high after command");
  // Select is dropped between words.
  gap_cs_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_GAP |-> !nvmChipSelect)
    else $error("select held between words");
  // Stored words do not move while a word is shifted.
  words_hold_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_SHIFT |=> $stable(loadedWords))
    else $error("stored words changed while shifting");

  // The first word becomes the vendor identification.
  ident_word_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_GAP && tick && st_reg.wordCnt == 3'h0 &&
    !restart |=> ident.vendorId == $past(st_reg.shift))
    else $error("vendor word not stored");
  // The second word becomes the sub-vendor identification.
  sub_word_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_GAP && tick && st_reg.wordCnt == 3'h1 &&
    !restart |=> ident.subVendorId == $past(st_reg.shift))
    else $error("sub-vendor word not stored");
  // The eighth word ends the automatic load.
  word_count_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_GAP && tick && st_reg.wordCnt == 3'h7 &&
    !restart |=> st_reg.state == NIL_DONE)
    else $error("load did not stop after eight words");

  // Done is only shown once loading has finished.
  load_clear_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state != NIL_DONE |-> !loadDone)
    else $error("done shown too early");
  // Done is held once loading has finished.
  done_level_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_DONE && !restart |=> loadDone)
    else $error("done not held");
  // Select is driven during manual access.
  done_oe_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_DONE && !restart |=> nvmSelectOe)
    else $error("select not driven after load");
  // Without the manual bit the link stays quiet.
  bang_idle_a: assert property (@(posedge clk) disable iff (!rstLocal_n)
    st_reg.state == NIL_DONE && !bitbang.manual && !restart |=>
    !nvmSerialClock && !nvmChipSelect && !nvmWriteLine)
    else $error("link moved without manual bit");

  // Main scenarios that the tests are meant to reach.
  load_cov: cover property (@(posedge clk) st_reg.state == NIL_GAP &&
    st_reg.wordCnt == 3'h7 && tick);
  skip_cov: cover property (@(posedge clk) st_reg.state == NIL_SENSE &&
    st_next.state == NIL_DONE);
  ir_cov: cover property (@(posedge clk) irModeBits == 8'hff);
  manual_cov: cover property (@(posedge clk) st_reg.state == NIL_DONE &&
    bitbang.manual && bitbang.clock);
  restart_cov: cover property (@(posedge clk) restart &&
    st_reg.state == NIL_DONE);
endmodule

// file: test/nil_nvm_model.sv
/*
  Serial memory model holding eight identification words.
  Assumes the loader drives select, serial clock and write line.
*/
`timescale 1ns/1ps
module nil_nvm_model (
  input wire logic cs, // Chip select.
  input wire logic sck, // Serial clock.
  input wire logic din, // Write line.
  output logic dout // Read line.
);
  logic [4:0] cnt;
  logic [5:0] addr;
  logic [15:0] word;
  initial dout = 1'b0;
  // Counts clocks and shifts in the address while selected.
  always @(posedge sck or negedge cs) begin
    if (!cs) cnt <= 5'h0;
    else begin
      cnt <= cnt + 5'h1;
      if (cnt > 5'h2 && cnt < 5'h9) addr <= {addr[4:0], din};
    end
  end
  // Data moves on the falling edge; releasing select inverts the line.
  always @(negedge sck or negedge cs) begin
    word = 16'h1357 * ({13'h0, addr[2:0]} + 16'h1);
    if (!cs) dout <= ~dout;
    else if (cnt > 5'h9 && cnt < 5'h1a) dout <= word[5'h19 - cnt];
    else dout <= 1'b0;
  end
endmodule

// file: test/test_nil_loader.sv
/*
  Self-checking bench for the identification loader.
  Assumes the memory model beside it and a 40 MHz clock.
*/
`timescale 1ns/1ps
module test_nil_loader;
  import nil_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic softReset = 1'b0;
  nil_bitbang_t bitbang = '0;
  logic strap = 1'b0;
  logic memOn = 1'b1;
  logic rdLine, sck, cs, oe, wr, rdBit, done, present;
  nil_ident_t ident;
  logic [127:0] words;
  logic [7:0] irBits;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  int lastRise = 0;
  int period = 0;
  // The board pull-up holds select high only when memory is fitted.
  wire logic selIn = oe ? cs : memOn;
  nil_loader uut (.clk(clk), .reset_n(reset_n), .softReset(softReset),
    .bitbang(bitbang), .infraredStrap(strap), .nvmReadLine(rdLine),
    .nvmSelectIn(selIn), .nvmSerialClock(sck), .nvmChipSelect(cs),
    .nvmSelectOe(oe), .nvmWriteLine(wr), .nvmReadBit(rdBit),
    .ident(ident), .loadedWords(words), .loadDone(done),
    .nvmPresent(present), .irModeBits(irBits));
  nil_nvm_model mem (.cs(cs), .sck(sck), .din(wr), .dout(rdLine));
  // Clock generator.
  initial forever #12.5 clk = ~clk;
  // Counts cycles and cuts a hang short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      bad_count = bad_count + 1;
      close_out();
    end
  end
  // Measures the serial clock period during the automatic load.
  always @(posedge sck) begin
    if (!done) period = cycles - lastRise;
    lastRise = cycles;
  end
  // Compares one value and reports a difference.
  task check(input logic [127:0] seen, input logic [127:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task close_out();
    $display("compares=%0d mismatches=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Waits, bounded, for the load to finish.
  task waitDone();
    int n;
    n = 0;
    repeat (10) @(posedge clk);
    while (done !== 1'b1 && n < 60000) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
  endtask
  // Pulses the reset pin with the strap and memory set up.
  task hwReset(input logic s, input logic m);
    @(posedge clk);
    reset_n <= 1'b0;
    strap <= s;
    memOn <= m;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    waitDone();
  endtask
  // Main sequence of tests.
  initial begin
    hwReset(1'b1, 1'b1);
    check(done, 1'b1);
    check(present, 1'b1);
    check(period, 256);
    for (int i = 0; i < 8; i++) begin
      check(words[16*i +: 16], 16'h1357 * (i + 1));
    end
    check(ident, {16'h1357, 16'h26ae});
    check(irBits, 8'hff);
    $display("load test done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      bitbang <= nil_bitbang_t'(i[3:0]);
      repeat (4) @(posedge clk);
      @(negedge clk);
      check({sck, cs, wr}, i[3] ? i[2:0] : 3'h0);
      check(rdBit, rdLine);
      check(oe, 1'b1);
    end
    $display("manual test done");
    @(posedge clk);
    bitbang <= '0;
    strap <= 1'b0;
    memOn <= 1'b0;
    softReset <= 1'b1;
    @(posedge clk);
    softReset <= 1'b0;
    waitDone();
    check(present, 1'b0);
    check(ident, {16'h0001, 16'h0002});
    check(irBits, 8'h00);
    $display("soft reset test done");
    hwReset(1'b1, 1'b0);
    check(irBits, 8'hff);
    $display("hardware reset test done");
    close_out();
  end
endmodule
